// file: core/rls_consts.vh
`ifndef RLS_CONSTS_VH
`define RLS_CONSTS_VH
// Register address on the control bus
`define RLS_ADDR_LINE_STATE 8'h08
// Line state codes
`define RLS_CODE_ACTIVE     3'h0
`define RLS_CODE_IDLE       3'h1
`define RLS_CODE_NOSIG      3'h2
`define RLS_CODE_RSVD       3'h3
`define RLS_CODE_MASTER     3'h4
`define RLS_CODE_HALT       3'h5
`define RLS_CODE_QUIET      3'h6
`define RLS_CODE_NOISE      3'h7
// Five-bit symbols
`define RLS_SYM_IDLE        5'h1f
`define RLS_SYM_QUIET       5'h00
`define RLS_SYM_HALT        5'h04
`define RLS_SYM_J           5'h18
`define RLS_SYM_K           5'h11
// Entry thresholds
`define RLS_IDLE_PAIRS      4'h2
`define RLS_LONG_PAIRS      4'h8
`define RLS_NOISE_EVENTS    5'h10
// Register field position and reset code
`define RLS_BIT_UNKNOWN     3
`define RLS_RESET_CODE      3'h2
// Reserved upper nibble of the status image
`define RLS_RSVD_VALUE      4'h0
`endif

// file: core/rls_pair_counter.v
`timescale 1ns/1ps
`include "rls_consts.vh"
module rls_pair_counter #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             sys_rst_i,
  // Pair stream
  input  wire             pair_vld_i,
  input  wire             match_i,
  input  wire [WIDTH-1:0] limit_i,
  // Result
  output wire             reached_o
);
  reg [WIDTH-1:0] cnt_ff;
  reg [WIDTH-1:0] nxt_cnt;

  // Saturating run length of back-to-back matching pairs
  always @* begin
    nxt_cnt = cnt_ff;
    if (pair_vld_i) begin
      if (!match_i)
        nxt_cnt = {WIDTH{1'b0}};
      else if (cnt_ff != {WIDTH{1'b1}})
        nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i)
      cnt_ff <= {WIDTH{1'b0}};
    else
      cnt_ff <= nxt_cnt;
  end

  // Threshold met on the pair that completes the run
  assign reached_o = pair_vld_i && match_i &&
                     (nxt_cnt >= limit_i);
endmodule

// file: core/rls_line_state.v
// Contract
// - Idle code after two back-to-back idle pairs.
// - No-signal code 010 when signal detect is deasserted.
// - Signal detect ignored while internal loopback is selected.
// - Stop mode defaults to 010; some patterns may set bit 0.
// - Code 011 never assigned to a defined state in normal use.
// - Master code after eight back-to-back halt-quiet pairs.
// - Halt code after eight back-to-back halt-halt pairs.
// - Quiet code after eight back-to-back quiet-quiet pairs.
// - Noise code 111 once sixteen noise events are seen.
// - Unknown flag in bit 3 until a known state is entered.
// - State code keeps last known state while unknown.
// - Reserved bits 7:4 zero from reset; writes have no effect.
// - Active code 000 after a start delimiter pair.
// - New state replaces the previous one; one state reported.
// - Reset forces the unknown state, flag reads one.
// - Bus writes ignored; only writes to address 08h raise the write reject flag.
`timescale 1ns/1ps
`include "rls_consts.vh"
module rls_line_state #(
  parameter SYM_W   = 5,
  parameter ADDR_W  = 8,
  parameter NOISE_W = 5
) (
  // Clock and reset
  input  wire              mclk_i,
  input  wire              sys_rst_i,
  // Decoded symbol pairs
  input  wire              pair_vld_i,
  input  wire [SYM_W-1:0]  sym_hi_i,
  input  wire [SYM_W-1:0]  sym_lo_i,
  input  wire              signal_detect_input_i,
  input  wire              noise_event_i,
  // Mode
  input  wire              loopback_i,
  input  wire              stop_mode_i,
  // Control bus
  input  wire              cb_sel_i,
  input  wire              cb_wr_i,
  input  wire [ADDR_W-1:0] cb_addr_i,
  output wire [7:0]        current_receive_line_state_o,
  output wire              write_reject_flag_o
);
  reg [2:0]         code_ff;
  reg               unknown_ff;
  reg [NOISE_W-1:0] noise_cnt_ff;
  reg               reject_ff;
  reg [2:0]         nxt_code;
  reg               nxt_unknown;
  reg [NOISE_W-1:0] nxt_noise_cnt;

  // Run detector slots, one per repeated pair pattern
  localparam RUN_N      = 4;
  localparam RUN_W      = 4;
  localparam RUN_IDLE   = 0;
  localparam RUN_MASTER = 1;
  localparam RUN_HALT   = 2;
  localparam RUN_QUIET  = 3;

  // Line state decisions, highest priority first
  localparam EV_STOP    = 4'h0;
  localparam EV_NOSIG   = 4'h1;
  localparam EV_NOISE   = 4'h2;
  localparam EV_ACTIVE  = 4'h3;
  localparam EV_IDLE    = 4'h4;
  localparam EV_MASTER  = 4'h5;
  localparam EV_HALT    = 4'h6;
  localparam EV_QUIET   = 4'h7;
  localparam EV_RSVD    = 4'h8;
  localparam EV_LOST    = 4'h9;
  localparam EV_HOLD    = 4'ha;

  wire [RUN_N-1:0] run_match;
  wire [RUN_N-1:0] run_hit;
  wire             idle_hit;
  wire             master_hit;
  wire             halt_hit;
  wire             quiet_hit;
  wire             any_run_hit;
  wire             sig_ok;
  wire             jk_pair;
  wire             other_pair;
  wire             lost_pair;
  wire             rsvd_left;
  wire             noise_hit;
  wire [3:0]       event_sel;

  // Pair matcher shared by all pair detectors
  function pair_is;
    input [SYM_W-1:0] hi;
    input [SYM_W-1:0] lo;
    input [SYM_W-1:0] want_hi;
    input [SYM_W-1:0] want_lo;
    begin
      pair_is = (hi == want_hi) && (lo == want_lo);
    end
  endfunction

  // First symbol expected by each run slot
  function [SYM_W-1:0] run_hi;
    input integer slot;
    begin
      case (slot)
        RUN_IDLE:   run_hi = `RLS_SYM_IDLE;
        RUN_MASTER: run_hi = `RLS_SYM_HALT;
        RUN_HALT:   run_hi = `RLS_SYM_HALT;
        RUN_QUIET:  run_hi = `RLS_SYM_QUIET;
        default:    run_hi = `RLS_SYM_IDLE;
      endcase
    end
  endfunction

  // Second symbol expected by each run slot
  function [SYM_W-1:0] run_lo;
    input integer slot;
    begin
      case (slot)
        RUN_IDLE:   run_lo = `RLS_SYM_IDLE;
        RUN_MASTER: run_lo = `RLS_SYM_QUIET;
        RUN_HALT:   run_lo = `RLS_SYM_HALT;
        RUN_QUIET:  run_lo = `RLS_SYM_QUIET;
        default:    run_lo = `RLS_SYM_IDLE;
      endcase
    end
  endfunction

  // Pairs needed before each run slot reports its state
  function [RUN_W-1:0] run_limit;
    input integer slot;
    begin
      case (slot)
        RUN_IDLE:   run_limit = `RLS_IDLE_PAIRS;
        RUN_MASTER: run_limit = `RLS_LONG_PAIRS;
        RUN_HALT:   run_limit = `RLS_LONG_PAIRS;
        RUN_QUIET:  run_limit = `RLS_LONG_PAIRS;
        default:    run_limit = `RLS_LONG_PAIRS;
      endcase
    end
  endfunction

  // Priority encoder over every condition that can move the state
  function [3:0] pick_event;
    input stop;
    input sig;
    input noise;
    input jk;
    input idle;
    input master;
    input halt;
    input quiet;
    input rsvd;
    input lost;
    begin
      if (stop)
        pick_event = EV_STOP;
      else if (!sig)
        pick_event = EV_NOSIG;
      else if (noise)
        pick_event = EV_NOISE;
      else if (jk)
        pick_event = EV_ACTIVE;
      else if (idle)
        pick_event = EV_IDLE;
      else if (master)
        pick_event = EV_MASTER;
      else if (halt)
        pick_event = EV_HALT;
      else if (quiet)
        pick_event = EV_QUIET;
      else if (rsvd)
        pick_event = EV_RSVD;
      else if (lost)
        pick_event = EV_LOST;
      else
        pick_event = EV_HOLD;
    end
  endfunction

  // Run-length counters, one per repeated pair pattern
  genvar gi;
  generate
    for (gi = 0; gi < RUN_N; gi = gi + 1) begin : g_run
      assign run_match[gi] = pair_is(sym_hi_i, sym_lo_i,
                                     run_hi(gi), run_lo(gi));

      rls_pair_counter #(
        .WIDTH      (RUN_W)
      ) u_run (
        .mclk_i     (mclk_i),
        .sys_rst_i  (sys_rst_i),
        .pair_vld_i (pair_vld_i),
        .match_i    (run_match[gi]),
        .limit_i    (run_limit(gi)),
        .reached_o  (run_hit[gi])
      );
    end
  endgenerate

  // Named views of the run detectors
  assign idle_hit    = run_hit[RUN_IDLE];
  assign master_hit  = run_hit[RUN_MASTER];
  assign halt_hit    = run_hit[RUN_HALT];
  assign quiet_hit   = run_hit[RUN_QUIET];
  assign any_run_hit = |run_hit;

  // Start delimiter and pairs that break any known run
  assign jk_pair = pair_vld_i &&
                   pair_is(sym_hi_i, sym_lo_i,
                           `RLS_SYM_J, `RLS_SYM_K);
  assign other_pair = pair_vld_i && !jk_pair && !(|run_match);

  // Data after a start delimiter is not a lost line state
  assign lost_pair = other_pair &&
                     (code_ff != `RLS_CODE_ACTIVE);

  // Stop mode leftover must not linger in normal operation
  assign rsvd_left = (code_ff == `RLS_CODE_RSVD);

  // Loopback masks signal detect
  assign sig_ok = loopback_i || signal_detect_input_i;

  // Sixteenth event; compare avoids wrap of a saturated count
  assign noise_hit = noise_event_i &&
      (noise_cnt_ff >= (`RLS_NOISE_EVENTS - 5'h01));

  // Noise event accumulator, cleared on lost signal, a start delimiter or a run hit
  always @* begin
    nxt_noise_cnt = noise_cnt_ff;
    if (!sig_ok || jk_pair || any_run_hit)
      nxt_noise_cnt = {NOISE_W{1'b0}};
    else if (noise_event_i && noise_cnt_ff != {NOISE_W{1'b1}})
      nxt_noise_cnt = noise_cnt_ff + {{(NOISE_W-1){1'b0}}, 1'b1};
  end

  // One decision per cycle
  assign event_sel = pick_event(stop_mode_i, sig_ok, noise_hit, jk_pair,
                                idle_hit, master_hit, halt_hit,
                                quiet_hit, rsvd_left, lost_pair);

  // Line state decision: code and flag chosen per event; EV_LOST keeps the code, EV_RSVD keeps the flag
  always @* begin
    nxt_code    = code_ff;
    nxt_unknown = unknown_ff;
    case (event_sel)
      EV_STOP: begin
        // Bit 0 may follow incoming patterns in stop mode
        nxt_code    = `RLS_CODE_NOSIG | {2'b00, jk_pair};
        nxt_unknown = 1'b0;
      end
      EV_NOSIG: begin
        nxt_code    = `RLS_CODE_NOSIG;
        nxt_unknown = 1'b0;
      end
      EV_NOISE: begin
        nxt_code    = `RLS_CODE_NOISE;
        nxt_unknown = 1'b0;
      end
      EV_ACTIVE: begin
        nxt_code    = `RLS_CODE_ACTIVE;
        nxt_unknown = 1'b0;
      end
      EV_IDLE: begin
        nxt_code    = `RLS_CODE_IDLE;
        nxt_unknown = 1'b0;
      end
      EV_MASTER: begin
        nxt_code    = `RLS_CODE_MASTER;
        nxt_unknown = 1'b0;
      end
      EV_HALT: begin
        nxt_code    = `RLS_CODE_HALT;
        nxt_unknown = 1'b0;
      end
      EV_QUIET: begin
        nxt_code    = `RLS_CODE_QUIET;
        nxt_unknown = 1'b0;
      end
      EV_RSVD: begin
        // Fall back to the no-signal default once stop mode ends
        nxt_code    = `RLS_CODE_NOSIG;
        nxt_unknown = unknown_ff;
      end
      EV_LOST: begin
        // Leave the known state, keep its code
        nxt_code    = code_ff;
        nxt_unknown = 1'b1;
      end
      default: begin
        nxt_code    = code_ff;
        nxt_unknown = unknown_ff;
      end
    endcase
  end

  // State register: code and flag in one edge
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      code_ff      <= `RLS_RESET_CODE;
      unknown_ff   <= 1'b1;
      noise_cnt_ff <= {NOISE_W{1'b0}};
    end else begin
      code_ff      <= nxt_code;
      unknown_ff   <= nxt_unknown;
      noise_cnt_ff <= nxt_noise_cnt;
    end
  end

  // Write reject: writes never reach the state register
  always @(posedge mclk_i) begin
    if (sys_rst_i)
      reject_ff <= 1'b0;
    else
      reject_ff <= cb_sel_i && cb_wr_i &&
                   (cb_addr_i == `RLS_ADDR_LINE_STATE);
  end

  // Reserved bits fixed at zero
  assign current_receive_line_state_o =
      {`RLS_RSVD_VALUE, unknown_ff, code_ff};
  assign write_reject_flag_o = reject_ff;
endmodule

// file: verification/rls_line_state_sva.sv
`timescale 1ns/1ps
module rls_line_state_sva #(
  parameter SYM_W  = 5,
  parameter ADDR_W = 8
) (
  // Watched ports
  input wire              mclk_i,
  input wire              sys_rst_i,
  input wire              pair_vld_i,
  input wire [SYM_W-1:0]  sym_hi_i,
  input wire [SYM_W-1:0]  sym_lo_i,
  input wire              signal_detect_input_i,
  input wire              noise_event_i,
  input wire              loopback_i,
  input wire              stop_mode_i,
  input wire              cb_sel_i,
  input wire              cb_wr_i,
  input wire [ADDR_W-1:0] cb_addr_i,
  input wire [7:0]        current_receive_line_state_o,
  input wire              write_reject_flag_o
);
  // Usable pair with no override pending
  wire [7:0] st  = current_receive_line_state_o;
  wire       ok  = pair_vld_i && (signal_detect_input_i || loopback_i) &&
                   !stop_mode_i && !noise_event_i;
  wire       idl = ok && sym_hi_i == 5'h1f && sym_lo_i == 5'h1f;
  wire       hlt = ok && sym_hi_i == 5'h04 && sym_lo_i == 5'h04;
  wire       jk  = ok && sym_hi_i == 5'h18 && sym_lo_i == 5'h11;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_rsvd_bits_zero: assert property (st[7:4] == 4'h0)
    else $error("reserved bits set");
  a_reset_unknown: assert property (disable iff (1'b0)
    sys_rst_i |=> st == 8'h0a) else $error("bad reset image");
  a_write_reject: assert property (cb_sel_i && cb_wr_i &&
    cb_addr_i == 8'h08 |=> write_reject_flag_o) else $error("no reject");
  a_no_signal: assert property (!signal_detect_input_i &&
    !loopback_i && !stop_mode_i |=> st[2:0] == 3'h2)
    else $error("no-signal code missing");
  a_stop_code: assert property (stop_mode_i |=>
    st[2:1] == 2'b01) else $error("stop code wrong");
  a_idle_entry: assert property (idl ##1 idl |=> st == 8'h01)
    else $error("idle not entered");
  a_active_entry: assert property (jk |=> st[3:0] == 4'h0)
    else $error("active not entered");
  a_halt_entry: assert property (hlt [*8] |=> st == 8'h05)
    else $error("halt not entered");
  a_unknown_keeps: assert property ($rose(st[3]) &&
    !$past(sys_rst_i) && !stop_mode_i && !$past(stop_mode_i) |->
    st[2:0] == $past(st[2:0])) else $error("code lost on unknown");
  a_no_reserved: assert property (!stop_mode_i &&
    !$past(stop_mode_i) |-> st[2:0] != 3'h3)
    else $error("reserved code outside stop mode");
endmodule
bind rls_line_state rls_line_state_sva #(.SYM_W(SYM_W), .ADDR_W(ADDR_W))
  u_sva (.*);

// file: verification/rls_media_rx.sv
`timescale 1ns/1ps
module rls_media_rx (
  // Clock
  input  wire       mclk_i,
  // Symbol pair stream
  output reg        pair_vld_o,
  output reg  [4:0] sym_hi_o,
  output reg  [4:0] sym_lo_o
);
  // Quiet bus at start
  initial begin
    pair_vld_o = 1'b0;
    sym_hi_o   = 5'h0a;
    sym_lo_o   = 5'h15;
  end
  // Back-to-back pairs, then inverted lines once released
  task send(input [4:0] hi, input [4:0] lo, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(negedge mclk_i);
        pair_vld_o = 1'b1;
        sym_hi_o   = hi;
        sym_lo_o   = lo;
      end
      @(negedge mclk_i);
      pair_vld_o = 1'b0;
      sym_hi_o   = ~hi;
      sym_lo_o   = ~lo;
    end
  endtask
endmodule

// file: verification/rls_line_state_test.sv
`timescale 1ns/1ps
module rls_line_state_test;
  reg         mclk_i, sys_rst_i, sd, nev, lb, stp, sel, wr;
  reg  [7:0]  addr, prev;
  reg  [12:0] p;
  reg  [31:0] r;
  wire        vld, rej;
  wire [4:0]  hi, lo;
  wire [7:0]  st;
  integer     k, miscompares, samples_checked;
  rls_media_rx src (.mclk_i(mclk_i), .pair_vld_o(vld), .sym_hi_o(hi),
    .sym_lo_o(lo));
  rls_line_state uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .pair_vld_i(vld), .sym_hi_i(hi), .sym_lo_i(lo),
    .signal_detect_input_i(sd), .noise_event_i(nev), .loopback_i(lb),
    .stop_mode_i(stp), .cb_sel_i(sel), .cb_wr_i(wr), .cb_addr_i(addr),
    .current_receive_line_state_o(st), .write_reject_flag_o(rej));
  // Expected register image and pattern table
  function [7:0] ex(input unk, input [2:0] code);
    ex = {4'h0, unk, code};
  endfunction
  function [12:0] pat(input integer i);
    pat = (i == 1) ? {5'h00, 5'h00, 3'h6} : {5'h04, 5'h00, 3'h4};
  endfunction
  // Compare and count
  task chk(input [7:0] got, input [7:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (got !== want) begin
        miscompares = miscompares + 1;
        $display("BAD %0t got %h want %h", $time, got, want);
      end
    end
  endtask
  // One noise event
  task pulse;
    begin
      @(negedge mclk_i) nev = 1'b1;
      @(negedge mclk_i) nev = 1'b0;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d bad %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Clock and watchdog
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    #20000;
    miscompares = miscompares + 1;
    give_verdict;
  end
  // Main sequence
  initial begin
    {sys_rst_i, sd, nev, lb, stp, sel, wr} = 7'h40;
    addr = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    r = $urandom(32'h1e48e30a);
    repeat (6) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    chk(st, ex(1'b1, 3'h2));
    sd = 1'b1;
    src.send(5'h1f, 5'h1f, 2);
    chk(st, ex(1'b0, 3'h1));
    src.send(5'h18, 5'h11, 1);
    chk(st, ex(1'b0, 3'h0));
    src.send(5'h04, 5'h04, 8);
    chk(st, ex(1'b0, 3'h5));
    for (k = 1; k < 3; k = k + 1) begin
      p = pat(k);
      prev = st;
      src.send(p[12:8], p[7:3], 7);
      chk(st, prev);
      src.send(p[12:8], p[7:3], 1);
      chk(st, ex(1'b0, p[2:0]));
    end
    $display("pair runs done");
    r = $urandom;
    src.send(5'h05 + {2'b00, r[2:0]}, r[9:5], 1);
    chk(st, ex(1'b1, 3'h4));
    repeat (15) pulse;
    chk(st, ex(1'b1, 3'h4));
    pulse;
    chk(st, ex(1'b0, 3'h7));
    sd = 1'b0;
    @(negedge mclk_i);
    chk(st, ex(1'b0, 3'h2));
    lb = 1'b1;
    src.send(5'h1f, 5'h1f, 2);
    chk(st, ex(1'b0, 3'h1));
    {lb, stp} = 2'b01;
    src.send(5'h18, 5'h11, 1);
    chk(st & 8'hfe, ex(1'b0, 3'h2));
    {sd, stp} = 2'b10;
    @(negedge mclk_i);
    chk(st, ex(1'b0, 3'h2));
    $display("line states done");
    for (k = 0; k < 4; k = k + 1) begin
      @(negedge mclk_i);
      r = $urandom;
      addr = (k == 0) ? 8'h08 : {r[7:4], 4'h0};
      {sel, wr} = 2'b11;
      prev = st;
      @(negedge mclk_i);
      {sel, wr} = 2'b00;
      chk({7'h00, rej}, {7'h00, k == 0});
      chk(st, prev);
      @(negedge mclk_i);
      chk({7'h00, rej}, 8'h00);
    end
    sys_rst_i = 1'b1;
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    chk(st, 8'h0a);
    $display("bus and reset done");
    give_verdict;
  end
endmodule
